// ===== pmm_pkg.sv
package pmm_pkg;
    localparam int NUM_PHASE = 3;
    localparam int SMP_W = 16;
    localparam int CLK_HZ = 125000000;
    // Sample rate and sag window
    localparam int SAMPLE_HZ = 8000;
    localparam int SAMPLE_DIV = CLK_HZ / SAMPLE_HZ;
    localparam int WINDOW_MS = 11;
    localparam int WINDOW_SAMPLES = SAMPLE_HZ * WINDOW_MS / 1000;
    localparam int SAG_MIN_HITS = 3;
    localparam int WINDOWS_NEEDED = 2;
    // Mode pin codes
    localparam logic [1:0] PIN_NORMAL = 2'h3;
    localparam logic [1:0] PIN_PARTIAL = 2'h2;
    localparam logic [1:0] PIN_DETECT = 2'h1;
    localparam logic [1:0] PIN_IDLE = 2'h0;
    // Status and enable bit positions
    localparam int SAG_BIT = 3;
    localparam int SAMPLED_NEUTRAL_BIT = 15;
    localparam int COMPUTED_NEUTRAL_BIT = 14;
    localparam int THREE_WIRE_BIT = 8;
    localparam int HALF_TURN_DEG = 180;
    // Partial mode access window
    localparam logic [9:0] PARTIAL_LO = 10'h014;
    localparam logic [9:0] PARTIAL_HI = 10'h01D;
    localparam logic [9:0] SPECIAL_0 = 10'h000;
    localparam logic [9:0] SPECIAL_1 = 10'h001;
    localparam logic [9:0] SPECIAL_3 = 10'h003;
    localparam logic [9:0] SPECIAL_7 = 10'h007;
    localparam logic [9:0] SPECIAL_E = 10'h00E;
    localparam logic [9:0] SPECIAL_F = 10'h00F;
    localparam int DEG_W = 9;
    localparam int EST_W = 32;

    typedef enum logic [1:0] {PMM_IDLE, PMM_NORMAL, PMM_PARTIAL, PMM_DETECT} pmm_mode_t;

    typedef struct packed {
        logic [NUM_PHASE-1:0] pos_enable;
        logic [NUM_PHASE-1:0] neg_enable;
    } pmm_detector_ctrl_t;

    typedef struct packed {
        logic [NUM_PHASE-1:0] volt_enable;
        logic [NUM_PHASE-1:0] curr_enable;
    } pmm_zero_cross_cfg_t;
endpackage

// ===== pmm_monitor.sv
`timescale 1ns/1ps
module pmm_monitor #(
    parameter int NUM_PHASE = pmm_pkg::NUM_PHASE,
    parameter int SMP_W = pmm_pkg::SMP_W,
    parameter int SAMPLE_DIV = pmm_pkg::SAMPLE_DIV,
    parameter int WINDOW_SAMPLES = pmm_pkg::WINDOW_SAMPLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire logic [NUM_PHASE-1:0] curr_pos_over,
    input wire logic [NUM_PHASE-1:0] curr_neg_over,
    input wire pmm_pkg::pmm_detector_ctrl_t detector_control_reg,
    input wire logic partial_result_ready,
    input wire logic [9:0] reg_access_addr,
    input wire logic [NUM_PHASE-1:0] volt_zero_cross,
    input wire logic [NUM_PHASE-1:0] curr_zero_cross,
    input wire pmm_pkg::pmm_zero_cross_cfg_t zero_cross_config_reg,
    input wire logic [NUM_PHASE*SMP_W-1:0] volt_abs_sample,
    input wire logic [SMP_W-1:0] sag_threshold,
    input wire logic [SMP_W-1:0] phase_loss_threshold,
    input wire logic [15:0] function_enable_first,
    input wire logic [15:0] function_enable_second,
    input wire logic [SMP_W-1:0] sampled_neutral_rms,
    input wire logic [SMP_W-1:0] computed_neutral_rms,
    input wire logic [SMP_W-1:0] sampled_neutral_threshold,
    input wire logic [SMP_W-1:0] computed_neutral_threshold,
    input wire logic status_clear,
    input wire logic [15:0] metering_mode_reg,
    input wire logic [pmm_pkg::DEG_W-1:0] a_to_c_degrees,
    input wire logic estimator_config_reg,
    input wire logic estimator_sample_valid,
    input wire logic signed [SMP_W-1:0] estimator_sample,
    output pmm_pkg::pmm_mode_t power_mode,
    output logic mode_violation,
    output logic [NUM_PHASE-1:0] comparator_power,
    output logic partial_analog_off,
    output logic reg_access_allowed,
    output logic pins_idle_state,
    output logic event_line_any,
    output logic event_line_all,
    output logic warning_output,
    output logic [15:0] system_status_first,
    output logic [15:0] system_status_second,
    output logic [NUM_PHASE-1:0] phase_lost,
    output logic [NUM_PHASE-1:0] zero_cross_out_volt,
    output logic [NUM_PHASE-1:0] zero_cross_out_curr,
    output logic phase_sequence_error,
    output logic estimator_on,
    output logic [pmm_pkg::EST_W-1:0] low_power_estimator
);
    logic [1:0] pins;
    pmm_pkg::pmm_mode_t next_mode;
    logic in_detect, in_partial, in_normal, mode_change;
    logic [NUM_PHASE-1:0] pos_hit, neg_hit, phase_over;
    logic [$clog2(SAMPLE_DIV)-1:0] div_cnt;
    logic sample_tick, window_end;
    logic [$clog2(WINDOW_SAMPLES+1)-1:0] smp_cnt;
    logic [NUM_PHASE-1:0][1:0] sag_hits, loss_hits;
    logic [NUM_PHASE-1:0] sag_prev, loss_prev, sag_low, loss_low;
    logic [NUM_PHASE-1:0] sag_now, loss_now;
    logic sag_event, neutral_irq, sag_irq;
    logic [NUM_PHASE-1:0] zx_prev;
    logic [NUM_PHASE-1:0] seq_seen;
    logic signed [pmm_pkg::EST_W-1:0] acc, next_acc;

    assign pins = {mode_select_hi, mode_select_lo};
    assign in_detect = (power_mode == pmm_pkg::PMM_DETECT);
    assign in_partial = (power_mode == pmm_pkg::PMM_PARTIAL);
    assign in_normal = (power_mode == pmm_pkg::PMM_NORMAL);
    assign mode_change = (next_mode != power_mode);

    always_comb begin
        case (pins)
            pmm_pkg::PIN_NORMAL: next_mode = pmm_pkg::PMM_NORMAL;
            pmm_pkg::PIN_PARTIAL: next_mode = pmm_pkg::PMM_PARTIAL;
            pmm_pkg::PIN_DETECT: next_mode = pmm_pkg::PMM_DETECT;
            default: next_mode = pmm_pkg::PMM_IDLE;
        endcase
    end

    // Mode register; direct non-idle hops are flagged
    always_ff @(posedge clock) begin
        if (reset) begin
            power_mode <= pmm_pkg::PMM_IDLE;
            mode_violation <= 1'b0;
        end else begin
            power_mode <= next_mode;
            if (mode_change && power_mode != pmm_pkg::PMM_IDLE
                && next_mode != pmm_pkg::PMM_IDLE) begin
                mode_violation <= 1'b1;
            end else if (next_mode == pmm_pkg::PMM_IDLE) begin
                mode_violation <= 1'b0;
            end
        end
    end

    // Comparator power and qualification
    always_comb begin
        for (int p = 0; p < NUM_PHASE; p++) begin
            comparator_power[p] = in_detect && (detector_control_reg.pos_enable[p]
                || detector_control_reg.neg_enable[p]);
            pos_hit[p] = in_detect && detector_control_reg.pos_enable[p] && curr_pos_over[p];
            neg_hit[p] = in_detect && detector_control_reg.neg_enable[p] && curr_neg_over[p];
            phase_over[p] = pos_hit[p] || neg_hit[p];
        end
    end

    assign partial_analog_off = in_partial;
    assign pins_idle_state = in_detect || (power_mode == pmm_pkg::PMM_IDLE);
    assign estimator_on = in_normal || in_partial;
    assign neutral_irq = (system_status_second[pmm_pkg::SAMPLED_NEUTRAL_BIT]
        && function_enable_second[pmm_pkg::SAMPLED_NEUTRAL_BIT])
        || (system_status_second[pmm_pkg::COMPUTED_NEUTRAL_BIT]
        && function_enable_second[pmm_pkg::COMPUTED_NEUTRAL_BIT]);
    assign sag_irq = system_status_first[pmm_pkg::SAG_BIT]
        && function_enable_first[pmm_pkg::SAG_BIT];

    always_comb begin
        reg_access_allowed = 1'b1;
        if (in_partial) begin
            reg_access_allowed = (reg_access_addr >= pmm_pkg::PARTIAL_LO
                && reg_access_addr <= pmm_pkg::PARTIAL_HI)
                || reg_access_addr == pmm_pkg::SPECIAL_0
                || reg_access_addr == pmm_pkg::SPECIAL_1
                || reg_access_addr == pmm_pkg::SPECIAL_3
                || reg_access_addr == pmm_pkg::SPECIAL_7
                || reg_access_addr == pmm_pkg::SPECIAL_E
                || reg_access_addr == pmm_pkg::SPECIAL_F;
        end
    end

    // Event line any: detection latch, partial result or sag warning in normal
    always_ff @(posedge clock) begin
        if (reset || mode_change) begin
            event_line_any <= 1'b0;
        end else if (in_detect && |phase_over) begin
            event_line_any <= 1'b1;
        end else if (in_partial && partial_result_ready) begin
            event_line_any <= 1'b1;
        end else if (in_normal) begin
            event_line_any <= sag_irq;
        end
    end

    // Event line all: detection latch, neutral overcurrent in normal, else low
    always_ff @(posedge clock) begin
        if (reset || mode_change) begin
            event_line_all <= 1'b0;
        end else if (in_detect) begin
            if (&phase_over) begin
                event_line_all <= 1'b1;
            end
        end else if (in_normal) begin
            event_line_all <= neutral_irq;
        end else begin
            event_line_all <= 1'b0;
        end
    end

    // 8 kHz sample enable and 11 ms window
    always_ff @(posedge clock) begin
        if (reset || !in_normal) begin
            div_cnt <= '0;
            smp_cnt <= '0;
        end else begin
            if (sample_tick) begin
                div_cnt <= '0;
                smp_cnt <= window_end ? '0 : smp_cnt + 1'b1;
            end else begin
                div_cnt <= div_cnt + 1'b1;
            end
        end
    end
    assign sample_tick = (div_cnt == ($bits(div_cnt))'(SAMPLE_DIV - 1));
    assign window_end = sample_tick
        && (smp_cnt == ($bits(smp_cnt))'(WINDOW_SAMPLES - 1));

    // Hit counters saturate at the minimum count
    always_ff @(posedge clock) begin
        if (reset || !in_normal) begin
            sag_hits <= '0;
            loss_hits <= '0;
            sag_prev <= '0;
            loss_prev <= '0;
            phase_lost <= '0;
        end else if (sample_tick) begin
            for (int p = 0; p < NUM_PHASE; p++) begin
                if (window_end) begin
                    sag_hits[p] <= '0;
                    loss_hits[p] <= '0;
                    sag_prev[p] <= sag_low[p];
                    loss_prev[p] <= loss_low[p];
                    phase_lost[p] <= loss_prev[p] && loss_low[p];
                end else begin
                    if (sag_now[p] && sag_hits[p] != 2'(pmm_pkg::SAG_MIN_HITS)) begin
                        sag_hits[p] <= sag_hits[p] + 1'b1;
                    end
                    if (loss_now[p] && loss_hits[p] != 2'(pmm_pkg::SAG_MIN_HITS)) begin
                        loss_hits[p] <= loss_hits[p] + 1'b1;
                    end
                end
            end
        end
    end
    // Window verdict counts the closing sample too
    always_comb begin
        for (int p = 0; p < NUM_PHASE; p++) begin
            sag_now[p] = volt_abs_sample[p*SMP_W +: SMP_W] > sag_threshold;
            loss_now[p] = volt_abs_sample[p*SMP_W +: SMP_W] > phase_loss_threshold;
            sag_low[p] = {1'b0, sag_hits[p]} + {2'b0, sag_now[p]} < 3'(pmm_pkg::SAG_MIN_HITS);
            loss_low[p] = {1'b0, loss_hits[p]} + {2'b0, loss_now[p]} < 3'(pmm_pkg::SAG_MIN_HITS);
        end
    end
    assign sag_event = window_end && |(sag_prev & sag_low);

    // Sticky status; set wins over clear
    always_ff @(posedge clock) begin
        if (reset) begin
            system_status_first <= '0;
            system_status_second <= '0;
        end else begin
            if (status_clear) begin
                system_status_first <= '0;
                system_status_second <= '0;
            end
            if (sag_event) begin
                system_status_first[pmm_pkg::SAG_BIT] <= 1'b1;
            end
            if (in_normal && sampled_neutral_rms > sampled_neutral_threshold) begin
                system_status_second[pmm_pkg::SAMPLED_NEUTRAL_BIT] <= 1'b1;
            end
            if (in_normal && computed_neutral_rms > computed_neutral_threshold) begin
                system_status_second[pmm_pkg::COMPUTED_NEUTRAL_BIT] <= 1'b1;
            end
        end
    end
    assign warning_output = sag_irq;

    // Zero-crossing outputs, gated by lost phases
    always_ff @(posedge clock) begin
        if (reset || !in_normal) begin
            zero_cross_out_volt <= '0;
            zero_cross_out_curr <= '0;
        end else begin
            zero_cross_out_volt <= volt_zero_cross & zero_cross_config_reg.volt_enable
                & ~phase_lost;
            zero_cross_out_curr <= curr_zero_cross & zero_cross_config_reg.curr_enable
                & ~phase_lost;
        end
    end

    // Phase sequence check
    always_ff @(posedge clock) begin
        if (reset || !in_normal) begin
            zx_prev <= '0;
            seq_seen <= '0;
            phase_sequence_error <= 1'b0;
        end else if (metering_mode_reg[pmm_pkg::THREE_WIRE_BIT]) begin
            phase_sequence_error <= (a_to_c_degrees
                <= pmm_pkg::DEG_W'(pmm_pkg::HALF_TURN_DEG));
        end else begin
            zx_prev <= volt_zero_cross;
            if (volt_zero_cross[0] && !zx_prev[0]) begin
                seq_seen <= 3'b001;
                phase_sequence_error <= seq_seen != 3'b111 && seq_seen != 3'b000;
            end else if (volt_zero_cross[1] && !zx_prev[1]) begin
                phase_sequence_error <= seq_seen != 3'b001;
                seq_seen <= 3'b011;
            end else if (volt_zero_cross[2] && !zx_prev[2]) begin
                phase_sequence_error <= seq_seen != 3'b011;
                seq_seen <= 3'b111;
            end
        end
    end

    // Low-power estimator: square sum or signed sum
    always_comb begin
        if (estimator_config_reg) begin
            next_acc = acc + pmm_pkg::EST_W'(estimator_sample);
        end else begin
            next_acc = acc + pmm_pkg::EST_W'(estimator_sample)
                * pmm_pkg::EST_W'(estimator_sample);
        end
    end
    always_ff @(posedge clock) begin
        if (reset || !estimator_on) begin
            acc <= '0;
            low_power_estimator <= '0;
        end else if (estimator_sample_valid) begin
            acc <= next_acc;
            low_power_estimator <= next_acc;
        end
    end
endmodule

// ===== pmm_monitor_assertions.sv
`timescale 1ns/1ps
module pmm_monitor_checker #(
    parameter int NUM_PHASE = 3,
    parameter int SMP_W = 16
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic mode_select_hi,
    input wire logic mode_select_lo,
    input wire logic [NUM_PHASE-1:0] curr_pos_over,
    input wire logic [NUM_PHASE-1:0] curr_neg_over,
    input wire pmm_pkg::pmm_detector_ctrl_t detector_control_reg,
    input wire logic [9:0] reg_access_addr,
    input wire pmm_pkg::pmm_mode_t power_mode,
    input wire logic mode_violation,
    input wire logic [NUM_PHASE-1:0] comparator_power,
    input wire logic partial_analog_off,
    input wire logic reg_access_allowed,
    input wire logic event_line_any,
    input wire logic event_line_all,
    input wire logic estimator_on
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [1:0] pins;
    logic det;
    logic part;
    logic [NUM_PHASE-1:0] hit;
    assign pins = {mode_select_hi, mode_select_lo};
    assign det = power_mode == pmm_pkg::PMM_DETECT;
    assign part = power_mode == pmm_pkg::PMM_PARTIAL;
    assign hit = (curr_pos_over & detector_control_reg.pos_enable)
        | (curr_neg_over & detector_control_reg.neg_enable);
    idle_entry_a: assert property (pins == 2'h0 |=> power_mode == pmm_pkg::PMM_IDLE)
        else $error("mode did not return to idle");
    detect_entry_a: assert property (power_mode == pmm_pkg::PMM_IDLE && pins == 2'h1 |=> det)
        else $error("detect code not decoded");
    any_latch_a: assert property (det && pins == 2'h1 && |hit |=> event_line_any)
        else $error("any line not raised");
    all_latch_a: assert property (det && pins == 2'h1 && &hit |=> event_line_all)
        else $error("all line not raised");
    latch_hold_a: assert property (det && pins == 2'h1 |=>
        event_line_any >= $past(event_line_any) && event_line_all >= $past(event_line_all))
        else $error("event line dropped in detect");
    exit_clear_a: assert property ($fell(det) |-> ##[0:1] !event_line_any && !event_line_all)
        else $error("event lines not cleared on exit");
    partial_hold_a: assert property (part && pins == 2'h2 && event_line_any |=> event_line_any)
        else $error("partial result line dropped");
    access_window_a: assert property (part |-> reg_access_allowed == (reg_access_addr inside
        {[10'h014:10'h01D], 10'h000, 10'h001, 10'h003, 10'h007, 10'h00E, 10'h00F}))
        else $error("partial access window wrong");
    comp_power_a: assert property (comparator_power == (det ?
        (detector_control_reg.pos_enable | detector_control_reg.neg_enable) : '0))
        else $error("comparator power wrong");
    hop_refuse_a: assert property (power_mode == pmm_pkg::PMM_NORMAL && pins == 2'h1
        |-> ##[1:2] mode_violation)
        else $error("direct hop not flagged");
    analog_off_a: assert property (partial_analog_off == part)
        else $error("analog off wrong");
    estimator_run_a: assert property (estimator_on == (part || power_mode == pmm_pkg::PMM_NORMAL))
        else $error("estimator enable wrong");
    cover property (det && event_line_all);
    cover property (part && event_line_any);
    cover property (mode_violation);
endmodule
bind pmm_monitor pmm_monitor_checker #(.NUM_PHASE(NUM_PHASE), .SMP_W(SMP_W)) pmm_monitor_checker_i (.*);

// ===== pmm_mcu_model.sv
`timescale 1ns/1ps
module pmm_mcu_model (
    input wire logic clock,
    input wire logic reset,
    input wire logic [1:0] target,
    input wire logic hop_ok,
    output logic mode_select_hi,
    output logic mode_select_lo
);
    logic [1:0] pins;
    assign {mode_select_hi, mode_select_lo} = pins;
    // Steps through idle unless a direct hop is commanded
    always @(posedge clock) begin
        if (reset) begin
            pins <= #1 2'h0;
        end else if (pins != 2'h0 && target != 2'h0 && target != pins && !hop_ok) begin
            pins <= #1 2'h0;
        end else begin
            pins <= #1 target;
        end
    end
endmodule

// ===== pmm_monitor_tb.sv
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin fails++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module pmm_monitor_tb;
    logic clock = 0, reset = 1, hop_ok = 0, partial_result_ready = 0, status_clear = 0;
    logic mode_select_hi, mode_select_lo, estimator_config_reg = 0, estimator_sample_valid = 0;
    logic [1:0] target = '0;
    logic [2:0] curr_pos_over = '0, curr_neg_over = '0, volt_zero_cross = '0;
    logic [2:0] curr_zero_cross = '0, hit;
    pmm_pkg::pmm_detector_ctrl_t detector_control_reg = '1;
    pmm_pkg::pmm_zero_cross_cfg_t zero_cross_config_reg = '1;
    logic [9:0] reg_access_addr = '0;
    logic [47:0] volt_abs_sample = '1;
    logic [15:0] sag_threshold = 16'h0100, phase_loss_threshold = 16'h0010;
    logic [15:0] function_enable_first = '0, function_enable_second = '0, metering_mode_reg = '0;
    logic [15:0] sampled_neutral_rms = '0, computed_neutral_rms = '0;
    logic [15:0] sampled_neutral_threshold = 16'h1000, computed_neutral_threshold = 16'h1000;
    logic [8:0] a_to_c_degrees = 9'h0C8;
    logic signed [15:0] estimator_sample = '0;
    pmm_pkg::pmm_mode_t power_mode;
    logic mode_violation, partial_analog_off, reg_access_allowed, pins_idle_state, event_line_any;
    logic event_line_all, warning_output, phase_sequence_error, estimator_on;
    logic [2:0] comparator_power, phase_lost, zero_cross_out_volt, zero_cross_out_curr;
    logic [15:0] system_status_first, system_status_second;
    logic [31:0] low_power_estimator;
    int fails = 0, comparisons = 0, sum;
    int order[6] = '{0, 1, 2, 0, 2, 1};
    pmm_monitor #(.SAMPLE_DIV(4), .WINDOW_SAMPLES(8)) pmm_monitor_i (.*);
    pmm_mcu_model pmm_mcu_model_i (.*);
    always #4 clock = ~clock;
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    function automatic pmm_pkg::pmm_mode_t exp_mode(input logic [1:0] p);
        case (p)
            2'h3: return pmm_pkg::PMM_NORMAL;
            2'h2: return pmm_pkg::PMM_PARTIAL;
            2'h1: return pmm_pkg::PMM_DETECT;
            default: return pmm_pkg::PMM_IDLE;
        endcase
    endfunction
    function automatic logic addr_ok(input logic [9:0] a);
        logic [9:0] special[$] = '{10'h000, 10'h001, 10'h003, 10'h007, 10'h00E, 10'h00F};
        return (a >= 10'h014 && a <= 10'h01D) || (a inside {special});
    endfunction
    task automatic go(input logic [1:0] p);
        int k;
        target = p;
        k = 0;
        while (power_mode !== exp_mode(p) && k < 10) begin
            cyc(1);
            k++;
        end
        `CHK("power_mode", exp_mode(p), power_mode)
        cyc(1);
    endtask
    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        results();
    end
    initial begin
        void'($urandom(32'h5BB9));
        cyc(2);
        reset = 0;
        `CHK("rst_mode", pmm_pkg::PMM_IDLE, power_mode)
        go(2'h3);
        estimator_config_reg = 1'($urandom);
        sum = 0;
        repeat (8) begin
            estimator_sample = 16'($urandom % 512 - 256);
            sum += estimator_config_reg ? int'(estimator_sample) : int'(estimator_sample) ** 2;
            estimator_sample_valid = 1;
            cyc(1);
        end
        estimator_sample_valid = 0;
        cyc(2);
        `CHK("estimator", 32'(sum), low_power_estimator)
        function_enable_second = 16'($urandom);
        sampled_neutral_rms = 16'h2000;
        computed_neutral_rms = 16'h0800;
        cyc(3);
        `CHK("neutral_s", 1'b1, system_status_second[15])
        `CHK("neutral_c", 1'b0, system_status_second[14])
        `CHK("all_line_s", function_enable_second[15], event_line_all)
        sampled_neutral_rms = 16'h0800;
        computed_neutral_rms = 16'h2000;
        status_clear = 1;
        cyc(1);
        status_clear = 0;
        cyc(2);
        `CHK("neutral_s_clr", 1'b0, system_status_second[15])
        `CHK("neutral_c_set", 1'b1, system_status_second[14])
        `CHK("all_line_c", function_enable_second[14], event_line_all)
        zero_cross_config_reg = 6'($urandom);
        volt_zero_cross = 3'($urandom);
        curr_zero_cross = 3'($urandom);
        cyc(2);
        `CHK("zx_volt", volt_zero_cross & zero_cross_config_reg.volt_enable, zero_cross_out_volt)
        `CHK("zx_curr", curr_zero_cross & zero_cross_config_reg.curr_enable, zero_cross_out_curr)
        volt_zero_cross = '0;
        cyc(2);
        for (int i = 0; i < 6; i++) begin
            volt_zero_cross = 3'(1 << order[i]);
            cyc(2);
            volt_zero_cross = '0;
            cyc(2);
            if (i == 2) `CHK("seq_ok", 1'b0, phase_sequence_error)
        end
        `CHK("seq_err", 1'b1, phase_sequence_error)
        metering_mode_reg = 16'h0100;
        for (int d = 0; d < 3; d++) begin
            a_to_c_degrees = d < 2 ? 9'h0B4 + 9'(d) : 9'($urandom % 360);
            cyc(2);
            `CHK("seq_3w", a_to_c_degrees <= 9'h0B4, phase_sequence_error)
        end
        metering_mode_reg = '0;
        volt_abs_sample = {16'hFFFF, 16'h0008, 16'h0050};
        function_enable_first = 16'($urandom);
        zero_cross_config_reg = '1;
        cyc(100);
        `CHK("sag_status", 1'b1, system_status_first[3])
        `CHK("sag_warn", function_enable_first[3], warning_output)
        `CHK("sag_any", function_enable_first[3], event_line_any)
        `CHK("phase_lost", 3'h2, phase_lost)
        volt_zero_cross = '1;
        curr_zero_cross = '1;
        cyc(2);
        `CHK("zx_lost_v", 3'h5, zero_cross_out_volt)
        `CHK("zx_lost_c", 3'h5, zero_cross_out_curr)
        volt_zero_cross = '0;
        volt_abs_sample = '1;
        go(2'h2);
        `CHK("analog_off", 1'b1, partial_analog_off)
        `CHK("est_on", 1'b1, estimator_on)
        for (int a = 0; a < 48; a++) begin
            reg_access_addr = a < 40 ? 10'(a) : 10'($urandom);
            cyc(1);
            `CHK("access", addr_ok(reg_access_addr), reg_access_allowed)
        end
        `CHK("any_pre", 1'b0, event_line_any)
        partial_result_ready = 1;
        cyc(1);
        partial_result_ready = 0;
        cyc(2);
        `CHK("any_partial", 1'b1, event_line_any)
        go(2'h0);
        cyc(1);
        `CHK("any_idle", 1'b0, event_line_any)
        for (int n = 0; n < 4; n++) begin
            go(2'h3);
            detector_control_reg = n == 0 ? 6'h3F : 6'($urandom);
            go(2'h0);
            go(2'h1);
            cyc(1);
            `CHK("comp_power", detector_control_reg.pos_enable | detector_control_reg.neg_enable,
                comparator_power)
            `CHK("pins_idle", 1'b1, pins_idle_state)
            `CHK("any_entry", 1'b0, event_line_any)
            curr_pos_over = n == 0 ? 3'h7 : 3'($urandom);
            curr_neg_over = 3'($urandom);
            hit = (curr_pos_over & detector_control_reg.pos_enable)
                | (curr_neg_over & detector_control_reg.neg_enable);
            cyc(1);
            curr_pos_over = '0;
            curr_neg_over = '0;
            cyc(2);
            `CHK("any_line", |hit, event_line_any)
            `CHK("all_line", &hit, event_line_all)
            go(2'h0);
            cyc(1);
            `CHK("all_exit", 1'b0, event_line_all)
        end
        go(2'h3);
        hop_ok = 1;
        target = 2'h1;
        cyc(3);
        `CHK("violation", 1'b1, mode_violation)
        hop_ok = 0;
        go(2'h0);
        `CHK("violation_clr", 1'b0, mode_violation)
        results();
    end
endmodule
